//--- hdl/pmp_pkg.sv
// Constants, enums and carriers of the parallel port block
package pmp_pkg;

  localparam logic [7:0] REG_CTRL1 = 8'h00;
  localparam logic [7:0] REG_CS1   = 8'h04;
  localparam logic [7:0] REG_CS2   = 8'h08;
  localparam logic [7:0] REG_CTRL2 = 8'h0c;
  localparam logic [7:0] REG_SOUT  = 8'h10;
  localparam logic [7:0] REG_SIN   = 8'h14;

  localparam logic [15:0] CTRL1_RESET = 16'h0000;
  localparam logic [15:0] CTRL1_WMASK = 16'hbbf7;
  localparam logic [15:0] CSCFG_RESET = 16'h0000;
  localparam logic [15:0] CSCFG_WMASK = 16'h01e0;
  localparam logic [15:0] CTRL2_RESET = 16'h0000;
  localparam logic [15:0] CTRL2_WMASK = 16'h0100;

  localparam int CT_ON   = 15;
  localparam int CT_IDLE = 13;
  localparam int CT_MUX  = 11;
  localparam int CT_MODE = 8;
  localparam int CT_CSF  = 6;
  localparam int CT_ALP  = 5;
  localparam int CT_ALM  = 4;
  localparam int CT_HOLD = 2;
  localparam int CT_IRQ  = 0;
  localparam int CS_SM   = 8;
  localparam int CS_ACK  = 7;
  localparam int CS_PORT_WIDTH_SEL = 5;
  localparam int C2_ALT  = 8;
  localparam int C2_BUSY = 15;
  localparam int CS_SEL_BIT = 23;

  typedef enum logic [1:0] {
    PM_LEGACY   = 2'b00,
    PM_BUFFERED = 2'b01,
    PM_ENHANCED = 2'b10,
    PM_MASTER   = 2'b11
  } pmp_mode_e;

  typedef enum logic [1:0] {
    PW_8  = 2'b00,
    PW_4  = 2'b01,
    PW_16 = 2'b10
  } pmp_width_e;

  localparam logic [1:0] IQ_CYCLE = 2'b01;
  localparam logic [1:0] IQ_BUF3  = 2'b11;
  localparam logic [1:0] CF_CS2_A15 = 2'b01;
  localparam logic [1:0] CF_BOTH_A  = 2'b10;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_ADDR = 2'b01,
    M_DATA = 2'b10,
    M_DONE = 2'b11
  } pmp_state_e;

  typedef struct packed {
    logic        we;
    logic [23:0] addr;
    logic [15:0] wdata;
  } pmp_req_s;

  typedef struct packed {
    logic        done;
    logic [15:0] rdata;
  } pmp_rsp_s;

endpackage

//--- hdl/pmp_port.sv
// Parallel master/slave port with Wishbone register slave
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
// Functional notes
// - 4-bit and 16-bit master only; 8-bit both
// - Chip select region turns access external
// - Alternate master may drive the port
// - 23 address lines, two selects, two acks
// - Enhanced slave: four-byte buffer addressed by address pins 1:0
// - Swap option exchanges four pin pairs
// - 16-bit muxed: address 15:8 carry data
// - Muxed: address 2,1,0 are latch strobes
// - 4-bit one phase: address 7:4 on data
// - Strobe pins change meaning with strobe style
// - High lane and low lane indicators
// - Port runs only while enabled
// - Idle halt stops port in idle
// - Mux field picks address phase count
// - Mode field picks master or slave kind
// - Placement field moves chip selects
// - Latch polarity bit sets strobe level
// - Smart latching drops the strobe of unchanged phases
// - Bus hold keeps last data value
// - Interrupt mode picks event source
// - Unimplemented control bits read zero
// - Width field: 8, 4 or 16 bits
// - Strobe style: separate or rw plus enable
module pmp_port
  import pmp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatI,
  output logic      [31:0] wbDatO,
  output logic             wbAck,
  input  wire logic        cpuIdle,
  input  wire logic        altPinSwap,
  input  wire logic        cpuValid,
  input  wire pmp_req_s    cpuReq,
  output pmp_rsp_s         cpuRsp,
  input  wire logic        altValid,
  input  wire pmp_req_s    altReq,
  output pmp_rsp_s         altRsp,
  output logic      [22:0] extAddrPinsOut,
  output logic      [22:0] extAddrPinsOe,
  input  wire logic [15:0] extAddrPinsIn,
  output logic      [15:0] extDataPinsOut,
  output logic      [15:0] extDataPinsOe,
  input  wire logic [15:0] extDataPinsIn,
  output logic             chipSelOne,
  output logic             chipSelTwo,
  output logic             writeStrobePinOut,
  output logic             readStrobePinOut,
  output logic             strobePinsOe,
  input  wire logic        writeStrobePinIn,
  input  wire logic        readStrobePinIn,
  input  wire logic        chipSelOneIn,
  output logic             byteLaneHi,
  output logic             byteLaneLo,
  input  wire logic        ackInOne,
  input  wire logic        ackInTwo,
  output logic             irqEvent
);

  function automatic logic [15:0] wrMerge(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel,
                                          input logic [15:0] mask);
    logic [15:0] upd;
    upd = old;
    if (sel[0]) upd[7:0] = dat[7:0];
    if (sel[1]) upd[15:8] = dat[15:8];
    return upd & mask;
  endfunction

  function automatic logic [7:0] addrByte(input logic [23:0] a,
                                          input logic [1:0]  p);
    case (p)
      2'd0:    return a[7:0];
      2'd1:    return a[15:8];
      default: return {1'b0, a[22:16]};
    endcase
  endfunction

  function automatic logic [23:0] swapPins(input logic [23:0] v,
                                           input logic        en);
    logic [23:0] s;
    s = v;
    if (en) begin
      s[23] = v[22];
      s[22] = v[23];
      s[5]  = v[18];
      s[18] = v[5];
      s[4]  = v[20];
      s[20] = v[4];
      s[3]  = v[21];
      s[21] = v[3];
    end
    return s;
  endfunction

  logic [15:0] ctrl1;
  logic [15:0] cs1Cfg;
  logic [15:0] cs2Cfg;
  logic [15:0] ctrl2;
  logic [7:0]  slvOut [4];
  logic [7:0]  slvIn  [4];
  pmp_state_e  mstState;
  pmp_req_s    curReq;
  logic        curAlt;
  logic        curCs2;
  logic [1:0]  phase;
  logic [7:0]  lastLatch [3];
  logic [2:0]  latchValid;
  logic        prevWr;
  logic        prevRd;
  logic [1:0]  wIdx;
  logic [1:0]  rIdx;

  // Register decode and read selection
  wire         wbReq   = wbCyc && wbStb && !wbAck;
  wire         wbWrite = wbReq && wbWe;
  wire [31:0]  slvInWord = {slvIn[3], slvIn[2], slvIn[1], slvIn[0]};
  wire [31:0]  slvOutWord = {slvOut[3], slvOut[2], slvOut[1], slvOut[0]};
  wire [15:0]  ctrl2Rd = ctrl2 | {mstState != M_IDLE, 15'h0000};
  wire [31:0]  rdWord =
    (wbAdr == REG_CTRL1) ? {16'h0000, ctrl1} :
    (wbAdr == REG_CS1)   ? {16'h0000, cs1Cfg} :
    (wbAdr == REG_CS2)   ? {16'h0000, cs2Cfg} :
    (wbAdr == REG_CTRL2) ? {16'h0000, ctrl2Rd} :
    (wbAdr == REG_SOUT)  ? slvOutWord :
    (wbAdr == REG_SIN)   ? slvInWord : 32'h0000_0000;

  // Operating conditions
  wire         portOn   = ctrl1[CT_ON];
  wire         running  = portOn && !(ctrl1[CT_IDLE] && cpuIdle);
  wire [1:0]   muxSel   = ctrl1[CT_MUX +: 2];
  wire [1:0]   modeSel  = ctrl1[CT_MODE +: 2];
  wire [1:0]   csPlace  = ctrl1[CT_CSF +: 2];
  wire         latch_strobe_polarity      = ctrl1[CT_ALP];
  wire [1:0]   irqSel   = ctrl1[CT_IRQ +: 2];
  wire         isMaster = running && (modeSel == PM_MASTER);
  wire         isSlave  = running && (modeSel != PM_MASTER);
  wire [15:0]  curCfg   = curCs2 ? cs2Cfg : cs1Cfg;
  wire [1:0]   width    = curCfg[CS_PORT_WIDTH_SEL +: 2];
  wire         w16      = (width == PW_16);
  wire         w4       = (width == PW_4);
  wire         smStyle  = curCfg[CS_SM];
  wire         ackSel   = curCs2 ? ackInTwo : ackInOne;
  wire         ackDone  = !curCfg[CS_ACK] || ackSel;
  wire         finish   = (mstState == M_DATA) && byteLaneLo && ackDone;
  wire         useAlt   = ctrl2[C2_ALT];
  wire         reqValid = useAlt ? altValid : cpuValid;
  wire pmp_req_s reqSel = useAlt ? altReq : cpuReq;
  wire [1:0]   lastPh   = muxSel - 2'd1;
  wire [7:0]   phByte   = addrByte(curReq.addr, phase);
  wire         needLatch = !(ctrl1[CT_ALM] && latchValid[phase] &&
                             lastLatch[phase] == phByte);

  // Master sequencing; a data phase ends only after its pins have stood a cycle
  always_ff @(posedge core_clk) begin
    if (reset || !isMaster) begin
      mstState <= M_IDLE;
    end else begin
      case (mstState)
        M_IDLE:  if (reqValid) mstState <= (muxSel != 2'b00) ? M_ADDR : M_DATA;
        M_ADDR:  if (phase == lastPh) mstState <= M_DATA;
        M_DATA:  if (finish) mstState <= M_DONE;
        M_DONE:  mstState <= M_IDLE;
        default: mstState <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      curReq <= '0;
      curAlt <= 1'b0;
      curCs2 <= 1'b0;
      phase  <= 2'd0;
    end else if (mstState == M_IDLE) begin
      curReq <= reqSel;
      curAlt <= useAlt;
      curCs2 <= reqSel.addr[CS_SEL_BIT];
      phase  <= 2'd0;
    end else if (mstState == M_ADDR) begin
      phase  <= phase + 2'd1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || !portOn) begin
      latchValid <= 3'b000;
      for (int i = 0; i < 3; i++) lastLatch[i] <= 8'h00;
    end else if (mstState == M_ADDR && needLatch) begin
      latchValid[phase] <= 1'b1;
      lastLatch[phase]  <= phByte;
    end
  end

  wire [15:0] rdCapture =
    w16 ? {(muxSel != 2'b00) ? extAddrPinsIn[15:8] : extDataPinsIn[15:8],
           extDataPinsIn[7:0]} :
    w4  ? {12'h000, extDataPinsIn[3:0]} : {8'h00, extDataPinsIn[7:0]};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cpuRsp <= '0;
      altRsp <= '0;
    end else begin
      cpuRsp.done <= finish && !curAlt;
      altRsp.done <= finish && curAlt;
      if (finish && !curReq.we) begin
        cpuRsp.rdata <= rdCapture;
        altRsp.rdata <= rdCapture;
      end
    end
  end

  // Pin values: latch strobes, chip selects, address, data and strobes
  wire        inAddr  = (mstState == M_ADDR) && needLatch;
  wire        inData  = (mstState == M_DATA);
  wire        busy    = (mstState != M_IDLE);
  wire [2:0]  latchAct = {inAddr && phase == 2'd2, inAddr && phase == 2'd1,
                          inAddr && phase == 2'd0};
  wire [2:0]  latchPin = latch_strobe_polarity ? latchAct : ~latchAct;
  wire        csOneAct = busy && !curCs2;
  wire        csTwoAct = busy && curCs2;
  wire        hiOnAddr = w16 && (muxSel != 2'b00);
  wire        dataRd   = inData && !curReq.we;
  wire        dataWr   = inData && curReq.we;
  wire        keep4    = w4 && (muxSel == 2'b01) && inData;

  logic [22:0] laOut;
  logic [22:0] laOe;
  always_comb begin
    laOut = curReq.addr[22:0];
    laOe  = {23{isMaster}};
    if (muxSel != 2'b00) laOut[2:0] = latchPin;
    if (hiOnAddr && dataWr) laOut[15:8] = curReq.wdata[15:8];
    if (hiOnAddr && dataRd) laOe[15:8] = 8'h00;
    if (csPlace == CF_CS2_A15 || csPlace == CF_BOTH_A) laOut[15] = csTwoAct;
    if (csPlace == CF_BOTH_A) laOut[14] = csOneAct;
  end

  wire [23:0] pinVal = swapPins({csTwoAct && csPlace != CF_CS2_A15
                                 && csPlace != CF_BOTH_A, laOut}, altPinSwap);
  wire [23:0] pinOe  = swapPins({isMaster, laOe}, altPinSwap);

  logic [15:0] dOut;
  logic [15:0] dDrive;
  always_comb begin
    dOut   = extDataPinsOut;
    dDrive = 16'h0000;
    if (inAddr || (mstState == M_ADDR)) begin
      dOut[7:0]   = phByte;
      dDrive[7:0] = 8'hff;
    end
    if (dataWr) begin
      dOut[7:0]   = curReq.wdata[7:0];
      dDrive[7:0] = w4 ? 8'h0f : 8'hff;
      if (w16 && muxSel == 2'b00) begin
        dOut[15:8]   = curReq.wdata[15:8];
        dDrive[15:8] = 8'hff;
      end
    end
    if (keep4) begin
      dOut[7:4]   = curReq.addr[7:4];
      dDrive[7:4] = 4'hf;
    end
    if (isSlave && readStrobePinIn && chipSelOneIn) begin
      dOut[7:0]   = slvOut[modeSel == PM_ENHANCED ? extAddrPinsIn[1:0] :
                           modeSel == PM_BUFFERED ? rIdx : 2'd0];
      dDrive[7:0] = 8'hff;
    end
  end

  // Keeper holds the last value on every lane while mastering, except in a read data phase
  wire        holdOn   = ctrl1[CT_HOLD] && isMaster && !dataRd;
  wire [15:0] next_dataOe = dDrive | {16{holdOn}};
  wire        next_wrPin = smStyle ? inData : dataWr;
  wire        next_rdPin = smStyle ? (busy && !curReq.we) : dataRd;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      extAddrPinsOut    <= '0;
      extAddrPinsOe     <= '0;
      chipSelTwo        <= 1'b0;
      chipSelOne        <= 1'b0;
      extDataPinsOut    <= '0;
      extDataPinsOe     <= '0;
      writeStrobePinOut <= 1'b0;
      readStrobePinOut  <= 1'b0;
      strobePinsOe      <= 1'b0;
      byteLaneHi        <= 1'b0;
      byteLaneLo        <= 1'b0;
    end else begin
      extAddrPinsOut    <= pinVal[22:0];
      extAddrPinsOe     <= pinOe[22:0];
      chipSelTwo        <= pinVal[23];
      chipSelOne        <= csOneAct && csPlace != CF_BOTH_A;
      extDataPinsOut    <= dOut;
      extDataPinsOe     <= next_dataOe;
      writeStrobePinOut <= next_wrPin;
      readStrobePinOut  <= next_rdPin;
      strobePinsOe      <= isMaster;
      byteLaneHi        <= inData && w16;
      byteLaneLo        <= inData;
    end
  end

  // Slave side: legacy, buffered and addressed buffers
  wire        slvWrEdge = isSlave && chipSelOneIn && writeStrobePinIn && !prevWr;
  wire        slvRdEdge = isSlave && chipSelOneIn && readStrobePinIn && !prevRd;
  wire [1:0]  wSlot = (modeSel == PM_ENHANCED) ? extAddrPinsIn[1:0] :
                      (modeSel == PM_BUFFERED) ? wIdx : 2'd0;
  wire [1:0]  rSlot = (modeSel == PM_ENHANCED) ? extAddrPinsIn[1:0] :
                      (modeSel == PM_BUFFERED) ? rIdx : 2'd0;
  wire        slot3 = (modeSel != PM_LEGACY) &&
                      ((slvWrEdge && wSlot == 2'd3) || (slvRdEdge && rSlot == 2'd3));
  wire        next_irq = (irqSel == IQ_CYCLE && (finish || slvWrEdge || slvRdEdge)) ||
                         (irqSel == IQ_BUF3 && slot3);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      prevWr   <= 1'b0;
      prevRd   <= 1'b0;
      wIdx     <= 2'd0;
      rIdx     <= 2'd0;
      irqEvent <= 1'b0;
      for (int i = 0; i < 4; i++) slvIn[i] <= 8'h00;
    end else begin
      prevWr   <= writeStrobePinIn && chipSelOneIn;
      prevRd   <= readStrobePinIn && chipSelOneIn;
      irqEvent <= next_irq;
      if (slvWrEdge) begin
        slvIn[wSlot] <= extDataPinsIn[7:0];
        wIdx         <= wIdx + 2'd1;
      end
      if (slvRdEdge) rIdx <= rIdx + 2'd1;
    end
  end

  // Register file and Wishbone answer, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl1  <= CTRL1_RESET;
      cs1Cfg <= CSCFG_RESET;
      cs2Cfg <= CSCFG_RESET;
      ctrl2  <= CTRL2_RESET;
      wbAck  <= 1'b0;
      wbDatO <= 32'h0000_0000;
      for (int i = 0; i < 4; i++) slvOut[i] <= 8'h00;
    end else begin
      wbAck  <= wbReq;
      wbDatO <= wbReq ? rdWord : 32'h0000_0000;
      if (wbWrite && wbAdr == REG_CTRL1) ctrl1 <= wrMerge(ctrl1, wbDatI, wbSel, CTRL1_WMASK);
      if (wbWrite && wbAdr == REG_CS1) cs1Cfg <= wrMerge(cs1Cfg, wbDatI, wbSel, CSCFG_WMASK);
      if (wbWrite && wbAdr == REG_CS2) cs2Cfg <= wrMerge(cs2Cfg, wbDatI, wbSel, CSCFG_WMASK);
      if (wbWrite && wbAdr == REG_CTRL2) ctrl2 <= wrMerge(ctrl2, wbDatI, wbSel, CTRL2_WMASK);
      if (wbWrite && wbAdr == REG_SOUT) begin
        for (int i = 0; i < 4; i++) if (wbSel[i]) slvOut[i] <= wbDatI[8*i +: 8];
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  halt_idle_a: assert property (!running |=> mstState == M_IDLE)
    else $error("port busy while halted");
  idle_stop_a: assert property (portOn && ctrl1[CT_IDLE] && cpuIdle |=> !strobePinsOe)
    else $error("strobes driven in idle halt");
  reserved_zero_a: assert property (wbAck && wbAdr == REG_CTRL1 && !wbWe
                                    |-> (wbDatO & ~{16'h0000, CTRL1_WMASK}) == 0)
    else $error("unimplemented bit read nonzero");
  latch_polarity_a: assert property ($past(mstState) == M_IDLE && $past(muxSel) != 2'b00
                                     |-> extAddrPinsOut[0] == !$past(latch_strobe_polarity))
    else $error("idle latch strobe level wrong");
  two_phase_a: assert property (mstState == M_IDLE ##1 mstState == M_ADDR && muxSel == 2'b10
                                |=> mstState == M_ADDR ##1 mstState == M_DATA)
    else $error("two address phases expected");
  irq_cycle_a: assert property (finish && irqSel == IQ_CYCLE |=> irqEvent)
    else $error("cycle end interrupt missing");
  strobe_style_a: assert property (inData && smStyle && curReq.we
                                   |=> writeStrobePinOut && !readStrobePinOut)
    else $error("enable strobe style wrong");
  wide_lane_a: assert property (byteLaneHi |-> $past(w16) && byteLaneLo)
    else $error("high lane without 16-bit width");
  ack_wait_a: assert property (inData && curCfg[CS_ACK] && !ackSel
                               |=> mstState == M_DATA)
    else $error("data phase left without ack");
  done_pulse_a: assert property (cpuRsp.done |=> !cpuRsp.done)
    else $error("response longer than one cycle");

endmodule

//--- dv/pmp_ext_mem.sv
// External memory model answering the parallel port strobes
`timescale 1ns/100ps
module pmp_ext_mem #(
  parameter int ACK_DLY = 3
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [22:0] addrPins,
  input  wire logic [15:0] dataPins,
  input  wire logic        chipSelOne,
  input  wire logic        chipSelTwo,
  input  wire logic        writeStrobe,
  input  wire logic        readStrobe,
  output logic      [15:0] dataIn,
  output logic             ackOne,
  output logic             ackTwo
);
  logic [15:0] mem [256];
  logic [15:0] lastVal;
  logic [3:0]  waitCnt;
  logic        sel;
  logic        rdNow;
  assign sel   = chipSelOne | chipSelTwo;
  assign rdNow = sel & readStrobe;
  // Released bus toggles every cycle so a stale value never looks valid
  assign dataIn = rdNow ? mem[addrPins[7:0]] : ~lastVal;
  always @(posedge core_clk) begin
    if (reset) begin
      lastVal <= 16'h0000;
      waitCnt <= 4'h0;
      ackOne  <= 1'b0;
      ackTwo  <= 1'b0;
    end else begin
      if (sel & writeStrobe) begin
        mem[addrPins[7:0]] <= dataPins;
      end
      lastVal <= dataIn;
      if (!(sel & (readStrobe | writeStrobe))) begin
        waitCnt <= 4'h0;
      end else if (waitCnt != 4'(ACK_DLY)) begin
        waitCnt <= waitCnt + 4'h1;
      end
      ackOne <= chipSelOne & (waitCnt == 4'(ACK_DLY));
      ackTwo <= chipSelTwo & (waitCnt == 4'(ACK_DLY));
    end
  end
endmodule

//--- dv/tb.sv
// Self-checking bench for the parallel port block
`timescale 1ns/100ps
module tb;
  import pmp_pkg::*;
  logic        core_clk, reset, wbCyc, wbStb, wbWe, wbAck, cpuIdle, cpuValid, altValid;
  logic [7:0]  wbAdr, seen;
  logic [31:0] wbDatI, wbDatO;
  pmp_req_s    cpuReq, altReq;
  pmp_rsp_s    cpuRsp, altRsp;
  logic [22:0] extAddrPinsOut, extAddrPinsOe;
  logic [15:0] extDataPinsOut, extDataPinsOe, extDataPinsIn, memData, q;
  logic        chipSelOne, chipSelTwo, writeStrobePinOut, readStrobePinOut;
  logic        byteLaneHi, byteLaneLo, ackInOne, ackInTwo, irqEvent;
  logic        strobePinsOe, altPinSwap, seenClr;
  logic [3:0]  wbSel, selMask;
  int          errCount, checkCount, n, nPlain;

  pmp_port i_dut(.core_clk, .reset, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI,
    .wbDatO, .wbAck, .cpuIdle, .altPinSwap, .cpuValid, .cpuReq, .cpuRsp, .altValid,
    .altReq, .altRsp, .extAddrPinsOut, .extAddrPinsOe, .extAddrPinsIn(16'h0000),
    .extDataPinsOut, .extDataPinsOe, .extDataPinsIn, .chipSelOne, .chipSelTwo,
    .writeStrobePinOut, .readStrobePinOut, .strobePinsOe, .writeStrobePinIn(1'b0),
    .readStrobePinIn(1'b0), .chipSelOneIn(1'b0), .byteLaneHi, .byteLaneLo, .ackInOne,
    .ackInTwo, .irqEvent);
  pmp_ext_mem #(.ACK_DLY(3)) i_mem(.core_clk, .reset, .addrPins(extAddrPinsOut),
    .dataPins(extDataPinsOut), .chipSelOne, .chipSelTwo, .writeStrobe(writeStrobePinOut),
    .readStrobe(readStrobePinOut), .dataIn(memData), .ackOne(ackInOne), .ackTwo(ackInTwo));
  // Wire level of each data pin from whoever drives it
  assign extDataPinsIn = (extDataPinsOe & extDataPinsOut) | (~extDataPinsOe & memData);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Sticky record of {latch high, irq, rd, wr, lane lo, lane hi, cs2, cs1}
  always @(posedge core_clk) begin
    seen <= seenClr ? 8'h00 : seen | {extAddrPinsOe[0] & extAddrPinsOut[0], irqEvent,
      readStrobePinOut,
      writeStrobePinOut, byteLaneLo, byteLaneHi, chipSelTwo, chipSelOne};
  end

  task automatic testDone(input bit hang);
    if (hang) errCount++;
    if (errCount == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int k;
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    wbSel <= selMask;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wbAck !== 1'b1 && k < 20);
    r = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (k >= 20) testDone(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(nm, exp, r);
  endtask
  // Master request; n reaches 30 when the port never answers
  task automatic mreq(input bit alt, input logic we, input logic [23:0] a,
                      input logic [15:0] d);
    @(posedge core_clk);
    seenClr <= 1'b1;
    @(posedge core_clk);
    seenClr <= 1'b0;
    cpuReq <= '{we, a, d};
    altReq <= '{we, a, d};
    cpuValid <= !alt;
    altValid <= alt;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while ((alt ? altRsp.done : cpuRsp.done) !== 1'b1 && n < 30);
    q = alt ? altRsp.rdata : cpuRsp.rdata;
    cpuValid <= 1'b0;
    altValid <= 1'b0;
    // One more edge lets the model's last write land
    @(posedge core_clk);
  endtask
  task automatic served(input bit exp);
    chk("answered", {31'h0, exp}, {31'h0, n < 30});
  endtask

  task automatic testRegs;
    logic [7:0]  offs [3] = '{REG_CTRL1, REG_CS1, REG_CTRL2};
    logic [15:0] msk  [3] = '{CTRL1_WMASK, CSCFG_WMASK, CTRL2_WMASK};
    for (int i = 0; i < 3; i++) begin
      rdc("reset value", offs[i], 32'h0);
      wr(offs[i], 32'hffffffff);
      rdc("write mask", offs[i], {16'h0, msk[i]});
      wr(offs[i], 32'h0);
    end
    selMask = 4'h2;
    wr(REG_CS1, 32'hffffffff);
    selMask = 4'hf;
    rdc("byte select", REG_CS1, 32'h0100);
    wr(REG_CS1, 32'h0);
    wr(8'h20, 32'hffffffff);
    rdc("unmapped", 8'h20, 32'h0);
  endtask
  task automatic testPlain;
    wr(REG_CTRL1, 32'h8301);
    mreq(0, 1'b1, 24'h000012, 16'h00a5);
    nPlain = n;
    served(1);
    chk("mem byte", 32'ha5, {24'h0, i_mem.mem[8'h12][7:0]});
    chk("write pins", 32'h59, {24'h0, seen});
    mreq(0, 1'b0, 24'h000012, 16'h0000);
    chk("read byte", 32'ha5, {24'h0, q[7:0]});
    chk("read pins", 32'h69, {24'h0, seen});
    chk("strobe oe", 32'h1, {31'h0, strobePinsOe});
    wr(REG_CTRL1, 32'h8305);
    @(posedge core_clk);
    chk("hold oe", 32'hffff, {16'h0, extDataPinsOe});
    chk("hold value", 32'ha5, {16'h0, extDataPinsOut});
    wr(REG_CTRL1, 32'h8301);
  endtask
  task automatic testWidths;
    wr(REG_CS2, 32'h0040);
    mreq(0, 1'b1, 24'h800034, 16'hbeef);
    chk("mem word", 32'hbeef, {16'h0, i_mem.mem[8'h34]});
    chk("cs2 pins", 32'h5e, {24'h0, seen});
    mreq(0, 1'b0, 24'h800034, 16'h0000);
    chk("read word", 32'hbeef, {16'h0, q});
    wr(REG_CS1, 32'h0020);
    mreq(0, 1'b1, 24'h000056, 16'h000c);
    chk("mem nibble", 32'hc, {28'h0, i_mem.mem[8'h56][3:0]});
    mreq(0, 1'b0, 24'h000056, 16'h0000);
    chk("read nibble", 32'hc, {28'h0, q[3:0]});
    wr(REG_CS1, 32'h0100);
    mreq(0, 1'b0, 24'h000012, 16'h0000);
    chk("strobe style", 32'h79, {24'h0, seen});
    wr(REG_CS1, 32'h0);
    wr(REG_CS2, 32'h0);
  endtask
  task automatic testRefuse;
    logic [15:0] ctl [5] = '{16'h0301, 16'h8001, 16'h8101, 16'h8201, 16'ha301};
    for (int i = 0; i < 5; i++) begin
      wr(REG_CTRL1, {16'h0, ctl[i]});
      cpuIdle <= (i == 4);
      mreq(0, 1'b1, 24'h000012, 16'h0011);
      served(0);
      chk("strobe oe", 32'h0, {31'h0, strobePinsOe});
    end
    wr(REG_CTRL1, 32'h8301);
    mreq(0, 1'b1, 24'h000012, 16'h0022);
    served(1);
    cpuIdle <= 1'b0;
  endtask
  task automatic testAck;
    wr(REG_CS1, 32'h0080);
    mreq(0, 1'b1, 24'h000013, 16'h0033);
    served(1);
    chk("ack wait", 32'h1, {31'h0, n > nPlain});
    wr(REG_CS1, 32'h0);
  endtask
  task automatic testAlt;
    wr(REG_CTRL2, 32'h0100);
    mreq(1, 1'b1, 24'h000077, 16'h005a);
    chk("alt byte", 32'h5a, {24'h0, i_mem.mem[8'h77][7:0]});
    mreq(0, 1'b1, 24'h000077, 16'h0000);
    served(0);
    wr(REG_CTRL2, 32'h0);
    altPinSwap <= 1'b1;
    mreq(0, 1'b1, 24'h000020, 16'h0001);
    chk("swapped pins", 32'h0004_0000, {9'h0, extAddrPinsOut});
    altPinSwap <= 1'b0;
  endtask
  task automatic testMux;
    wr(REG_CTRL1, 32'h8b21);
    mreq(0, 1'b1, 24'h000099, 16'h0044);
    chk("latch strobe", 32'h1, {31'h0, seen[7]});
    chk("mux length", nPlain + 1, n);
    wr(REG_CTRL1, 32'h9331);
    mreq(0, 1'b1, 24'h0000aa, 16'h0044);
    chk("new address", 32'h1, {31'h0, seen[7]});
    mreq(0, 1'b1, 24'h0000aa, 16'h0045);
    chk("same address", 32'h0, {31'h0, seen[7]});
    chk("skip length", nPlain + 2, n);
  endtask

  initial begin
    errCount = 0;
    checkCount = 0;
    seenClr = 1'b1;
    selMask = 4'hf;
    wbSel = 4'h0;
    reset = 1'b1;
    {wbCyc, wbStb, wbWe, cpuIdle, cpuValid, altValid, altPinSwap} = 7'h00;
    wbAdr = 8'h00;
    wbDatI = 32'h0;
    cpuReq = '0;
    altReq = '0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    testRegs();
    testPlain();
    testWidths();
    testRefuse();
    testAck();
    testAlt();
    testMux();
    testDone(0);
  end
endmodule
